// File: logic/fsp_pkg.sv
// shared constants for the relative seek and perpendicular mode block
// assumes a 32-bit axi4-lite register bus with byte addresses
package fsp_pkg;
  // ==========================================================
  // register map, byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_PERP = 8'h04;
  localparam logic [7:0] OFS_CONF = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_TRACK = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;
  localparam logic [7:0] OFS_RESET = 8'h18;
  // ==========================================================
  // field positions
  localparam int CMD_DIR = 8;
  localparam int CMD_DRV = 9;
  localparam int CMD_RSEEK = 11;
  localparam int CMD_RECAL = 12;
  localparam int PERP_GAP = 0;
  localparam int PERP_WG = 1;
  localparam int PERP_FLAGS = 2;
  localparam int PERP_OW = 7;
  localparam int CONF_RATE = 16;
  localparam int STAT_BUSY = 8;
  localparam int STAT_DONE = 9;
  localparam int SB0_FAULT = 4;
  localparam int SB0_END = 5;
  localparam int SB0_IC = 6;
  localparam int RST_SOFT = 0;
  // ==========================================================
  // reset values and codes
  localparam int NDRV = 4;
  localparam logic [15:0] IVAL_RST = 16'h0100;
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] RECAL_MAX = 8'h50;
  // ==========================================================
  // gap and timing byte counts
  localparam logic [5:0] GAP_CONV = 6'h16;
  localparam logic [5:0] GAP_PERP_1M = 6'h29;
  localparam logic [5:0] OSC_CONV = 6'h18;
  localparam logic [5:0] OSC_PERP_1M = 6'h2B;
  localparam logic [5:0] WG_CONV = 6'h00;
  localparam logic [5:0] WG_PERP_500 = 6'h13;
  localparam logic [5:0] WG_PERP_1M = 6'h26;
  // ==========================================================
  // operation in progress
  typedef enum logic [1:0] {OP_NONE, OP_RSEEK, OP_RECAL} fsp_op_type;
endpackage

// File: logic/fsp_stepper.sv
// step pulse sequencer: a counted burst of spaced pulses
// assumes abort and start come from logic on aclk
`timescale 1ns/1ns
`default_nettype none
module fsp_stepper
  import fsp_pkg::*;
#(
  parameter int CW = 8,
  parameter int IW = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request
  input wire logic start,
  input wire logic [CW-1:0] count,
  input wire logic [IW-1:0] interval,
  input wire logic abort,
  // status
  output logic step_q,
  output logic busy,
  output logic done_q,
  output logic aborted_q
);
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} fsp_step_state_type;
  fsp_step_state_type state_q;
  logic [CW-1:0] remain_q;
  logic [IW-1:0] timer_q;
  logic [IW-1:0] ival_q;
  logic [IW:0] since_q;
  logic seen_q;

  assign busy = (state_q == ST_RUN);

  // ==========================================================
  // sequencer: first pulse interval+1 cycles after start, then one per interval+1 cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      remain_q <= '0;
      timer_q <= '0;
      ival_q <= '0;
      step_q <= 1'b0;
      done_q <= 1'b0;
      aborted_q <= 1'b0;
    end else begin
      step_q <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: if (start) begin
          state_q <= ST_RUN;
          remain_q <= count;
          timer_q <= interval; // newly selected drive's home sense needs time to settle
          ival_q <= interval;
          aborted_q <= 1'b0;
        end
        ST_RUN: if (timer_q != '0) begin
          timer_q <= timer_q - 1'b1;
        end else if (abort) begin
          // abort only at a decision point, once the sense has settled
          state_q <= ST_IDLE;
          done_q <= 1'b1;
          aborted_q <= 1'b1;
        end else if (remain_q == '0) begin
          state_q <= ST_IDLE; // last interval elapsed, sense settled
          done_q <= 1'b1;
        end else begin
          step_q <= 1'b1;
          remain_q <= remain_q - 1'b1;
          timer_q <= ival_q;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // helper: cycles since the previous pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_q <= '0;
      seen_q <= 1'b0;
    end else begin
      since_q <= step_q ? (IW+1)'(1) : since_q + 1'b1;
      seen_q <= (seen_q && busy) || step_q;
    end
  end

  step_spacing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    step_q && seen_q |-> since_q > {1'b0, ival_q})
    else $error("step pulses closer than the step interval");
endmodule
`default_nettype wire

// File: logic/fsp_mode_dec.sv
// recording mode decode: gap, oscillator and write gate byte counts
// assumes mode bits and flags come from registers on aclk
`timescale 1ns/1ns
`default_nettype none
module fsp_mode_dec
  import fsp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // programmed mode
  input wire logic gap_bit,
  input wire logic write_gate_mode_bit_bit,
  input wire logic [NDRV-1:0] drive_flags,
  input wire logic [1:0] drive,
  input wire logic rate_1m,
  // timing to the data path
  output logic [5:0] post_header_spacing,
  output logic [5:0] pll_oscillator_enable,
  output logic [5:0] write_gate_gap_bytes,
  output logic precomp_zero
);
  // ==========================================================
  // flags only count while both global bits are clear
  wire global_conv = !gap_bit && !write_gate_mode_bit_bit;
  wire designated = global_conv && drive_flags[drive];
  wire perp_1m = (gap_bit && write_gate_mode_bit_bit) || (designated && rate_1m);
  wire perp_500 = (gap_bit && !write_gate_mode_bit_bit) || (designated && !rate_1m);
  wire [5:0] gap_d = perp_1m ? GAP_PERP_1M : GAP_CONV;
  wire [5:0] osc_d = perp_1m ? OSC_PERP_1M : OSC_CONV;
  wire [5:0] wg_d = perp_1m ? WG_PERP_1M : (perp_500 ? WG_PERP_500 : WG_CONV);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      post_header_spacing <= GAP_CONV;
      pll_oscillator_enable <= OSC_CONV;
      write_gate_gap_bytes <= WG_CONV;
      precomp_zero <= 1'b0;
    end else begin
      post_header_spacing <= gap_d;
      pll_oscillator_enable <= osc_d;
      write_gate_gap_bytes <= wg_d;
      precomp_zero <= designated;
    end
  end

  gap_1m_a: assert property (@(posedge aclk) disable iff (!aresetn)
    gap_bit && write_gate_mode_bit_bit |=> post_header_spacing == GAP_PERP_1M && pll_oscillator_enable == OSC_PERP_1M)
    else $error("1 Mbps perpendicular gap or oscillator count wrong");
  wg_500_a: assert property (@(posedge aclk) disable iff (!aresetn)
    gap_bit && !write_gate_mode_bit_bit |=> write_gate_gap_bytes == WG_PERP_500 && post_header_spacing == GAP_CONV)
    else $error("500 Kbps perpendicular decode wrong");
  reserved_conv_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !gap_bit && write_gate_mode_bit_bit |=> write_gate_gap_bytes == WG_CONV && !precomp_zero)
    else $error("reserved mode not treated as conventional");
  auto_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    global_conv && drive_flags[drive] |=> precomp_zero && write_gate_gap_bytes != WG_CONV)
    else $error("designated drive not in perpendicular mode");
endmodule
`default_nettype wire

// File: logic/fsp_ctrl.sv
// relative seek / recalibrate sequencer and perpendicular mode control
// assumes an axi4-lite master on aclk and a drive with step/dir/home lines
// Function
// - step direction is inward when the direction bit is 1, outward when 0.
// - relative seek issues exactly the count of pulses, at most 255, no compare.
// - only one relative seek runs at a time.
// - stepping outward past track zero sets the fault bit 4 of status byte zero.
// - present track ends as old value plus count, modulo 256.
// - recalibrate steps outward to home sense, error after 80 pulses.
// - commands use the present track value; no extended-area record is kept.
// - mode bits decode to conventional, 500K, reserved-conventional, 1M.
// - post-header gap is 41 bytes in 1M perpendicular, 22 otherwise.
// - oscillator enables after 24 bytes conventionally, 43 in 1M mode.
// - write gate opens early: 38 gap bytes at 1M, 19 at 500K.
// - with both mode bits 0, flagged drives run perpendicular at the data rate.
// - designated drives write with zero precompensation.
// - drive flags change only with overwrite set, ignored if a mode bit is set.
// - software reset clears only the two mode bits.
// - hardware reset clears mode bits and all drive flags.
// - no result phase; completion is flagged and host senses status.
// - step pulses are spaced by the programmed step interval.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module fsp_ctrl
  import fsp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // drive side
  input wire logic home_track_sense,
  output logic step_pulse,
  output logic step_dir_in,
  output logic [1:0] drive_sel,
  // timing to the data path
  output logic [5:0] post_header_spacing,
  output logic [5:0] pll_oscillator_enable,
  output logic [5:0] write_gate_gap_bytes,
  output logic precomp_zero
);
  // ==========================================================
  // state
  logic home_m_q, home_s_q;
  logic aw_v_q, w_v_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_q;
  logic [31:0] w_q, rdata_q;
  logic [3:0] ws_q;
  logic [1:0] bresp_q, rresp_q;
  logic gap_q, write_gate_mode_bit_q, rate_1m_q, dir_q, done_q;
  logic [NDRV-1:0] flags_q;
  logic [15:0] ival_q;
  logic [7:0] rtc_q, sb0_q, pc_q;
  logic [1:0] drv_q;
  fsp_op_type op_q;
  logic [7:0] track_q [NDRV];
  logic st_busy, st_done, st_abort;

  // ==========================================================
  // home sense synchroniser, pin is asynchronous
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      home_m_q <= 1'b0;
      home_s_q <= 1'b0;
    end else begin
      home_m_q <= home_track_sense;
      home_s_q <= home_m_q;
    end
  end

  // ==========================================================
  // axi write: address and data held until both present
  wire wr_fire = aw_v_q && w_v_q && !bvalid_q;
  wire [ADDR_W-3:0] wa = aw_q[ADDR_W-1:2];
  wire wr_cmd = wr_fire && wa == OFS_CMD[ADDR_W-1:2];
  wire wr_perp = wr_fire && wa == OFS_PERP[ADDR_W-1:2];
  wire wr_conf = wr_fire && wa == OFS_CONF[ADDR_W-1:2];
  wire wr_stat = wr_fire && wa == OFS_STAT[ADDR_W-1:2];
  wire wr_rst = wr_fire && wa == OFS_RESET[ADDR_W-1:2];
  wire wr_ro = wr_fire && (wa == OFS_TRACK[ADDR_W-1:2] || wa == OFS_MODE[ADDR_W-1:2]);
  wire wr_hit = wr_cmd || wr_perp || wr_conf || wr_stat || wr_rst || wr_ro;
  wire [31:0] wbits = w_q & {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  assign s_axi_awready = !aw_v_q;
  assign s_axi_wready = !w_v_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_v_q <= 1'b0;
      w_v_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_q <= '0;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_v_q) begin
        aw_v_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_v_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_v_q) begin
        w_v_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_v_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // perpendicular mode and configuration registers
  wire soft_rst = wr_rst && wbits[RST_SOFT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q <= 1'b0;
      write_gate_mode_bit_q <= 1'b0;
      flags_q <= '0;
      ival_q <= IVAL_RST;
      rate_1m_q <= 1'b0;
    end else begin
      if (soft_rst) begin
        gap_q <= 1'b0;
        write_gate_mode_bit_q <= 1'b0;
      end else if (wr_perp && ws_q[0]) begin
        gap_q <= w_q[PERP_GAP];
        write_gate_mode_bit_q <= w_q[PERP_WG];
        if (w_q[PERP_OW]) begin
          flags_q <= w_q[PERP_FLAGS +: NDRV];
        end
      end
      if (wr_conf) begin
        ival_q <= (wbits[15:0]) | (ival_q & ~{{8{ws_q[1]}}, {8{ws_q[0]}}});
        if (ws_q[2]) begin
          rate_1m_q <= w_q[CONF_RATE];
        end
      end
    end
  end

  // ==========================================================
  // command start: a busy sequencer refuses new commands
  wire start_rs = wr_cmd && ws_q[1] && w_q[CMD_RSEEK] && !st_busy;
  wire start_rc = wr_cmd && ws_q[1] && w_q[CMD_RECAL] && !w_q[CMD_RSEEK] && !st_busy;
  wire start_any = start_rs || start_rc;
  wire [7:0] st_count = start_rc ? RECAL_MAX : w_q[7:0];
  // outward at home means the next pulse would pass track zero
  wire abort_w = home_s_q && ((op_q == OP_RSEEK && !dir_q) || op_q == OP_RECAL);
  // home reached on the last commanded pulse is not a fault
  wire rs_fault = op_q == OP_RSEEK && st_abort && pc_q != rtc_q;
  wire rc_fail = op_q == OP_RECAL && !st_abort;
  wire sense_clr = wr_stat && ws_q[1] && w_q[STAT_DONE];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_q <= OP_NONE;
      rtc_q <= 8'h00;
      dir_q <= 1'b0;
      drv_q <= 2'h0;
      step_dir_in <= 1'b0;
    end else if (start_any) begin
      op_q <= start_rs ? OP_RSEEK : OP_RECAL;
      rtc_q <= w_q[7:0];
      dir_q <= start_rs && w_q[CMD_DIR];
      drv_q <= w_q[CMD_DRV +: 2];
      step_dir_in <= start_rs && w_q[CMD_DIR];
    end
  end

  // completion status; a completion beats a same-cycle sense clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sb0_q <= 8'h00;
      done_q <= 1'b0;
    end else if (st_done) begin
      done_q <= 1'b1;
      sb0_q <= 8'h00;
      sb0_q[1:0] <= drv_q;
      sb0_q[SB0_END] <= 1'b1;
      sb0_q[SB0_FAULT] <= rs_fault || rc_fail;
      sb0_q[SB0_IC +: 2] <= (rs_fault || rc_fail) ? IC_ABNORMAL : IC_NORMAL;
    end else if (sense_clr) begin
      done_q <= 1'b0;
    end
  end

  // step pulses counted per operation, checked by assertions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= 8'h00;
    end else begin
      pc_q <= start_any ? 8'h00 : pc_q + {7'h00, step_pulse};
    end
  end

  // ==========================================================
  // present track per drive, wraps modulo 256 with no extended record
  for (genvar i = 0; i < NDRV; i++) begin : g_trk
    wire sel = drv_q == 2'(i);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        track_q[i] <= 8'h00;
      end else if (sel && st_done && op_q == OP_RECAL && st_abort) begin
        track_q[i] <= 8'h00;
      end else if (sel && step_pulse) begin
        track_q[i] <= step_dir_in ? track_q[i] + 8'h01 : track_q[i] - 8'h01;
      end
    end
  end

  fsp_stepper #(
    .CW(8),
    .IW(16)
  ) u_step (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_any),
    .count(st_count),
    .interval(ival_q),
    .abort(abort_w),
    .step_q(step_pulse),
    .busy(st_busy),
    .done_q(st_done),
    .aborted_q(st_abort)
  );

  fsp_mode_dec u_mode (
    .aclk(aclk),
    .aresetn(aresetn),
    .gap_bit(gap_q),
    .write_gate_mode_bit_bit(write_gate_mode_bit_q),
    .drive_flags(flags_q),
    .drive(drv_q),
    .rate_1m(rate_1m_q),
    .post_header_spacing(post_header_spacing),
    .pll_oscillator_enable(pll_oscillator_enable),
    .write_gate_gap_bytes(write_gate_gap_bytes),
    .precomp_zero(precomp_zero)
  );
  assign drive_sel = drv_q;

  // ==========================================================
  // axi read: one read under way, data registered
  wire [ADDR_W-3:0] ra = s_axi_araddr[ADDR_W-1:2];
  wire [31:0] rd_cmd = {19'h0_0000, 2'h0, drv_q, dir_q, rtc_q};
  wire [31:0] rd_perp = {24'h00_0000, 2'h0, flags_q, write_gate_mode_bit_q, gap_q};
  wire [31:0] rd_conf = {15'h0000, rate_1m_q, ival_q};
  wire [31:0] rd_stat = {22'h00_0000, done_q, st_busy, sb0_q};
  wire [31:0] rd_trk = {track_q[3], track_q[2], track_q[1], track_q[0]};
  wire [31:0] rd_mode = {7'h00, precomp_zero, 2'h0, write_gate_gap_bytes, 2'h0,
                         pll_oscillator_enable, 2'h0, post_header_spacing};
  wire rd_hit = ra <= OFS_RESET[ADDR_W-1:2];
  wire [31:0] rd_word = ra == OFS_CMD[ADDR_W-1:2] ? rd_cmd :
                        ra == OFS_PERP[ADDR_W-1:2] ? rd_perp :
                        ra == OFS_CONF[ADDR_W-1:2] ? rd_conf :
                        ra == OFS_STAT[ADDR_W-1:2] ? rd_stat :
                        ra == OFS_TRACK[ADDR_W-1:2] ? rd_trk :
                        ra == OFS_MODE[ADDR_W-1:2] ? rd_mode : 32'h0000_0000;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rs_end_s;
    st_done && op_q == OP_RSEEK && !st_abort;
  endsequence
  sequence rs_fault_s;
    st_done && op_q == OP_RSEEK && st_abort && pc_q != rtc_q;
  endsequence

  step_dir_a: assert property (step_pulse |-> step_dir_in == (op_q == OP_RSEEK && dir_q))
    else $error("step direction does not follow the command");
  step_count_a: assert property (rs_end_s |-> pc_q == rtc_q)
    else $error("relative seek pulse count differs from command");
  one_seek_a: assert property (st_busy && wr_cmd |=> $stable(rtc_q) && $stable(op_q))
    else $error("command accepted while a seek runs");
  fault_bit_a: assert property (rs_fault_s |=> sb0_q[SB0_FAULT] && sb0_q[SB0_IC +: 2] == IC_ABNORMAL)
    else $error("outward limit fault not flagged");
  track_step_a: assert property (step_pulse && step_dir_in |=> track_q[drv_q] == 8'($past(track_q[drv_q]) + 8'h01))
    else $error("present track not advanced by one");
  recal_max_a: assert property (op_q == OP_RECAL |-> pc_q <= RECAL_MAX)
    else $error("recalibrate exceeded its pulse limit");
  soft_rst_a: assert property (soft_rst |=> !gap_q && !write_gate_mode_bit_q && $stable(flags_q))
    else $error("software reset disturbed drive flags");
  flag_ow_a: assert property (wr_perp && !w_q[PERP_OW] |=> $stable(flags_q))
    else $error("drive flags changed without overwrite");
  done_set_a: assert property (st_done |=> done_q ##0 sb0_q[SB0_END])
    else $error("completion not reported");
endmodule
`default_nettype wire

// File: verification/fsp_drive.sv
// drive model: one head per drive, home sense at track 0
// assumes step, direction and select come from the controller on aclk
`timescale 1ns/1ns
`default_nettype none
module fsp_drive (
  // controller side
  input wire logic aclk,
  input wire logic step_pulse,
  input wire logic step_dir_in,
  input wire logic [1:0] drive_sel,
  // sense back
  output logic home_track_sense
);
  // ==========
  // head positions may run past 255, the controller cannot know
  int pos[4] = '{0, 0, 0, 0};
  int steps = 0;
  always @(posedge aclk) begin
    if (step_pulse) begin
      steps++;
      if (step_dir_in)
        pos[drive_sel]++;
      else if (pos[drive_sel] > 0)
        pos[drive_sel]--;
    end
  end
  // mechanical stop: the head never goes below track 0
  assign home_track_sense = (pos[drive_sel] == 0);
endmodule
`default_nettype wire

// File: verification/tb.sv
// bench for the seek sequencer and perpendicular mode control
// assumes fsp_ctrl on an axi4-lite master with the drive model on its pins
`timescale 1ns/1ns
`default_nettype none
module tb
  import fsp_pkg::*;
;
  // ==========
  // signals, named as the ports so that .* joins them
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, drive_sel;
  logic home_track_sense, step_pulse, step_dir_in, precomp_zero;
  logic [5:0] post_header_spacing, pll_oscillator_enable, write_gate_gap_bytes;
  logic [31:0] me[4] = '{32'h0000_1816, 32'h0013_0016, 32'h0000_1816, 32'h0026_2B29};
  logic [31:0] mm[4] = '{32'h003F_3F3F, 32'h003F_003F, 32'h003F_3F3F, 32'h003F_3F3F};
  int n_errors = 0, checked = 0, cyc = 0, gap_c = 0, last_gap = 0;
  fsp_ctrl fsp_ctrl_inst (.*);
  fsp_drive fsp_drive_inst (.*);
  initial begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end
  // pulse spacing and a hang guard, both in clock cycles
  always @(posedge aclk) begin
    gap_c++;
    cyc++;
    if (step_pulse) begin
      last_gap = gap_c;
      gap_c = 0;
    end
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  // ==========
  // bus tasks; a leading edge keeps two calls off one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ao, wo;
    {ao, wo} = 2'b00;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!(ao && wo)) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        ao = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        wo = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d & m, e);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  // start a command, wait for done, then sense to clear it
  task automatic go(input logic [31:0] c, output logic [31:0] s, output int d);
    logic [1:0] r;
    d = fsp_drive_inst.steps;
    wr(OFS_CMD, c, r);
    s = '0;
    for (int k = 0; k < 600 && s[9] !== 1'b1; k++) rd(OFS_STAT, s, r);
    chk({22'h0, s[9], 9'h0}, 32'h0000_0200);
    wr(OFS_STAT, 32'h0000_0200, r);
    d = fsp_drive_inst.steps - d;
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========
  // test sequence
  initial begin
    logic [31:0] s;
    logic [1:0] r;
    int d;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    do_reset();
    rdc(OFS_MODE, 32'h0000_1816, 32'h013F_3F3F);
    wr(OFS_CONF, 32'h0000_0003, r);
    d = fsp_drive_inst.steps;
    wr(OFS_CMD, 32'h0000_0905, r);
    wr(OFS_CMD, 32'h0000_0B01, r);
    go(32'h0000_0000, s, d);
    chk(fsp_drive_inst.steps, 32'd5);
    chk({31'h0, step_dir_in}, 32'h0000_0001);
    chk(last_gap, 32'd4);
    rdc(OFS_TRACK, 32'h0000_0005, 32'h0000_FFFF);
    $display("test seek in done");
    go(32'h0000_09FF, s, d);
    chk(d, 32'd255);
    rdc(OFS_TRACK, 32'h0000_0004, 32'h0000_00FF);
    go(32'h0000_0A03, s, d);
    chk(s & 32'h0000_00D3, 32'h0000_0051);
    rdc(OFS_TRACK, 32'h0000_0004, 32'h0000_FFFF);
    $display("test wrap and limit done");
    go(32'h0000_1000, s, d);
    chk(d, 32'd80);
    chk(s & 32'h0000_00D3, 32'h0000_0050);
    go(32'h0000_0D0A, s, d);
    go(32'h0000_1400, s, d);
    chk(s & 32'h0000_00D3, 32'h0000_0002);
    rdc(OFS_TRACK, 32'h0000_0000, 32'h00FF_0000);
    $display("test recalibrate done");
    for (int i = 0; i < 4; i++) begin
      wr(OFS_PERP, 32'(i), r);
      rdc(OFS_MODE, me[i], mm[i]);
      chk({26'h0, post_header_spacing}, {26'h0, me[i][5:0]});
    end
    $display("test mode table done");
    wr(OFS_PERP, 32'h0000_0090, r);
    rdc(OFS_MODE, 32'h0113_0016, 32'h013F_003F);
    chk({31'h0, precomp_zero}, 32'h0000_0001);
    wr(OFS_PERP, 32'h0000_0000, r);
    rdc(OFS_PERP, 32'h0000_0010, 32'h0000_00FF);
    wr(OFS_CONF, 32'h0001_0003, r);
    rdc(OFS_MODE, 32'h0026_0000, 32'h003F_0000);
    wr(OFS_PERP, 32'h0000_0003, r);
    wr(OFS_RESET, 32'h0000_0001, r);
    rdc(OFS_PERP, 32'h0000_0010, 32'h0000_00FF);
    $display("test drive flags done");
    rd(8'h1C, s, r);
    chk(s, 32'h0000_0000);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h1C, 32'h0000_0001, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    do_reset();
    rdc(OFS_PERP, 32'h0000_0000, 32'h0000_00FF);
    $display("test bus and reset done");
    finish_test();
  end
endmodule
`default_nettype wire
